// ---- rtl/wdt_top.sv ----
// Windowed watchdog timer with prescaler, postscaler, window check and power-save wake.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Prescaler divides source ticks by 32 or 128 per one configuration bit.
// - Nominal 31 kHz source gives base time-out of 1 ms or 4 ms.
// - Four-bit postscale field selects 16 ratios, 1:1 up to 1:32768.
// - Source is low-power RC, secondary oscillator or system timer; sleep uses RC.
// - Enabled watchdog also requests its selected clock source on.
// - Any reset or completed clock switch clears counter, prescaler, postscaler.
// - Entering or leaving sleep or idle clears counter, prescaler, postscaler.
// - Clear instruction in normal execution clears counter, prescaler, postscaler.
// - Enabled watchdog keeps counting during sleep and idle.
// - Time-out in sleep or idle wakes core; sleep and idle flags stay set.
// - Sticky time-out flag cleared only by software or by srst_in.
// - In windowed mode clear works only in last quarter of the period at postscale 1:4 or more; at 1:2 from half, at 1:1 always.
// - In windowed mode an early clear causes a watchdog reset.
// - Window-disable bit programmed zero enables windowed mode.
// - Enable field: 11 always on, 10 software bit, 00 always off.
// - Software enable bit starts watchdog; cleared on every device reset.
module wdt_top
	import wdt_pkg::*;
(
	input  wire logic                          mclk_in,
	input  wire logic                          srst_in,
	input  wire logic                          rc_tick_in,
	input  wire logic                          sec_osc_tick_in,
	input  wire logic                          systmr_tick_in,
	input  wire logic [wdt_pkg::CLK_SEL_W-1:0] clk_source_sel_in,
	input  wire logic                          prescale_select_cfg_in,
	input  wire logic [wdt_pkg::POST_SEL_W-1:0] postscale_select_cfg_in,
	input  wire logic                          window_disable_cfg_in,
	input  wire logic [wdt_pkg::EN_CFG_W-1:0]  watchdog_enable_cfg_in,
	input  wire logic                          soft_watchdog_enable_set_in,
	input  wire logic                          soft_watchdog_enable_clr_in,
	input  wire logic                          timeout_flag_clr_in,
	input  wire logic                          sleep_flag_clr_in,
	input  wire logic                          idle_flag_clr_in,
	input  wire logic                          watchdog_clear_instr_in,
	input  wire logic                          power_save_sleep_in,
	input  wire logic                          power_save_idle_in,
	input  wire logic                          power_save_exit_in,
	input  wire logic                          osc_switch_done_in,
	output logic                               wdt_enabled_out,
	output logic                               clk_source_on_out,
	output logic [wdt_pkg::CLK_SEL_W-1:0]      clk_source_used_out,
	output logic                               soft_watchdog_enable_out,
	output logic                               timeout_flag_out,
	output logic                               sleep_flag_out,
	output logic                               idle_flag_out,
	output logic                               wake_out,
	output logic                               device_reset_out,
	output logic [wdt_pkg::POST_W-1:0]         post_count_out
);
	import wdt_pkg::*;

	logic [2:0]        tick_sync1_ff;
	logic [2:0]        tick_sync2_ff;
	logic [2:0]        tick_prev_ff;
	logic [PRE_W-1:0]  pre_cnt_ff;
	logic [POST_W-1:0] post_cnt_ff;
	logic              soft_en_ff;
	logic              to_flag_ff;
	logic              sleep_ff;
	logic              idle_ff;
	wdt_pmode_e        pmode_ff;
	logic              wake_ff;
	logic              rst_req_ff;
	logic              en_ff;
	logic              src_on_ff;
	logic [CLK_SEL_W-1:0] src_used_ff;
	logic [2:0]        tick_rise;
	logic              enabled;
	logic [CLK_SEL_W-1:0] src_sel;
	logic              src_tick;
	logic              pre_done;
	logic [POST_W-1:0] post_last;
	logic              timeout;
	logic              clr_normal;
	logic              early_clear;
	logic              counter_clear;

	// Terminal value of a counter that divides by two to the power of the select value.
	function automatic logic [POST_W-1:0] last_of(input logic [POST_SEL_W-1:0] sel);
		last_of = POST_W'((32'h1 << sel) - 32'h1);
	endfunction

	// Tick inputs come from other oscillators, so each passes two flops first.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			tick_sync1_ff <= 3'h0;
			tick_sync2_ff <= 3'h0;
			tick_prev_ff  <= 3'h0;
		end else begin
			tick_sync1_ff <= {systmr_tick_in, sec_osc_tick_in, rc_tick_in};
			tick_sync2_ff <= tick_sync1_ff;
			tick_prev_ff  <= tick_sync2_ff;
		end
	end

	assign tick_rise = tick_sync2_ff & ~tick_prev_ff;

	always_comb begin
		unique case (watchdog_enable_cfg_in)
			EN_ALWAYS_ON:  enabled = 1'b1;
			EN_SOFTWARE:   enabled = soft_en_ff;
			default:       enabled = 1'b0;
		endcase
	end

	always_comb begin
		// Sleep stops the faster sources, so the RC oscillator takes over there.
		if (pmode_ff == WDT_SLEEP) begin
			src_sel = CLK_SEL_RC;
		end else if (clk_source_sel_in == CLK_SEL_SEC || clk_source_sel_in == CLK_SEL_SYS) begin
			src_sel = clk_source_sel_in;
		end else begin
			src_sel = CLK_SEL_RC;
		end
	end

	assign src_tick = tick_rise[src_sel];

	// A 31 kHz source over 32 or 128 gives the nominal 1 ms or 4 ms base period.
	assign pre_done = src_tick && (prescale_select_cfg_in ?
		(pre_cnt_ff == PRE_W'((1 << PRE_LONG_BITS) - 1)) :
		(pre_cnt_ff == PRE_W'((1 << PRE_SHORT_BITS) - 1)));
	assign post_last = last_of(postscale_select_cfg_in);
	assign timeout   = enabled && pre_done && (post_cnt_ff == post_last);

	assign clr_normal  = watchdog_clear_instr_in && (pmode_ff == WDT_RUN);
	// Window opens once the count reaches three quarters of the postscaled period.
	// The compare is kept two bits wider so the longest period cannot wrap.
	assign early_clear = clr_normal && enabled && !window_disable_cfg_in &&
		({2'h0, post_cnt_ff} <
		((({2'h0, post_last} + 18'h1) * 18'h3) >> 2));

	assign counter_clear = clr_normal || osc_switch_done_in || power_save_sleep_in ||
		power_save_idle_in || power_save_exit_in || !enabled || timeout;

	always_ff @(posedge mclk_in) begin
		if (srst_in || counter_clear) begin
			pre_cnt_ff  <= '0;
			post_cnt_ff <= '0;
		end else if (pre_done) begin
			pre_cnt_ff  <= '0;
			post_cnt_ff <= post_cnt_ff + POST_W'(1);
		end else if (src_tick) begin
			pre_cnt_ff  <= pre_cnt_ff + PRE_W'(1);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			soft_en_ff <= 1'b0;
		end else if (soft_watchdog_enable_set_in) begin
			soft_en_ff <= 1'b1;
		end else if (soft_watchdog_enable_clr_in) begin
			soft_en_ff <= 1'b0;
		end
	end

	// The flag is kept across the watchdog reset so software can see the cause.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			to_flag_ff <= 1'b0;
		end else if (timeout || early_clear) begin
			to_flag_ff <= 1'b1;
		end else if (timeout_flag_clr_in) begin
			to_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			pmode_ff <= WDT_RUN;
		end else if (power_save_sleep_in) begin
			pmode_ff <= WDT_SLEEP;
		end else if (power_save_idle_in) begin
			pmode_ff <= WDT_IDLE;
		end else if (power_save_exit_in || (timeout && pmode_ff != WDT_RUN)) begin
			pmode_ff <= WDT_RUN;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			sleep_ff <= 1'b0;
			idle_ff  <= 1'b0;
		end else begin
			if (power_save_sleep_in) begin
				sleep_ff <= 1'b1;
			end else if (sleep_flag_clr_in) begin
				sleep_ff <= 1'b0;
			end
			if (power_save_idle_in) begin
				idle_ff <= 1'b1;
			end else if (idle_flag_clr_in) begin
				idle_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			wake_ff    <= 1'b0;
			rst_req_ff <= 1'b0;
		end else begin
			wake_ff    <= timeout && (pmode_ff != WDT_RUN);
			rst_req_ff <= (timeout && pmode_ff == WDT_RUN) || early_clear;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			en_ff       <= 1'b0;
			src_on_ff   <= 1'b0;
			src_used_ff <= CLK_SEL_RC;
		end else begin
			en_ff       <= enabled;
			src_on_ff   <= enabled;
			src_used_ff <= src_sel;
		end
	end

	assign wdt_enabled_out          = en_ff;
	assign clk_source_on_out        = src_on_ff;
	assign clk_source_used_out      = src_used_ff;
	assign soft_watchdog_enable_out = soft_en_ff;
	assign timeout_flag_out         = to_flag_ff;
	assign sleep_flag_out           = sleep_ff;
	assign idle_flag_out            = idle_ff;
	assign wake_out                 = wake_ff;
	assign device_reset_out         = rst_req_ff;
	assign post_count_out           = post_cnt_ff;
endmodule
`default_nettype wire

// ---- rtl/wdt_pkg.sv ----
// Package with constants and types for the windowed watchdog timer.
package wdt_pkg;
	localparam int          PRE_SHORT_BITS   = 5;
	localparam int          PRE_LONG_BITS    = 7;
	localparam int          PRE_W            = 7;
	localparam int          POST_W           = 16;
	localparam int          POST_SEL_W       = 4;
	localparam int          EN_CFG_W         = 2;
	localparam int          CLK_SEL_W        = 2;
	localparam int          RC_OSC_HZ        = 31000;
	localparam int          BASE_SHORT_US    = 1000;
	localparam int          BASE_LONG_US     = 4000;
	localparam logic [1:0]  EN_ALWAYS_ON     = 2'h3;
	localparam logic [1:0]  EN_SOFTWARE      = 2'h2;
	localparam logic [1:0]  EN_ALWAYS_OFF    = 2'h0;
	localparam logic [1:0]  CLK_SEL_RC       = 2'h0;
	localparam logic [1:0]  CLK_SEL_SEC      = 2'h1;
	localparam logic [1:0]  CLK_SEL_SYS      = 2'h2;
	localparam int          CFG_WIN_DIS_BIT  = 7;
	localparam int          CTRL_SWEN_BIT    = 5;
	localparam int          CTRL_TO_BIT      = 4;
	typedef enum logic [1:0] {
		WDT_RUN,
		WDT_SLEEP,
		WDT_IDLE
	} wdt_pmode_e;
endpackage

// ---- tb/wdt_chk.sv ----
// Assertion checker bound to the watchdog timer ports.
`timescale 1ns/1ns
`default_nettype none
module wdt_chk
	import wdt_pkg::*;
(
	input wire logic        mclk_in,
	input wire logic        srst_in,
	input wire logic [1:0]  watchdog_enable_cfg_in,
	input wire logic        timeout_flag_clr_in,
	input wire logic        power_save_sleep_in,
	input wire logic        power_save_exit_in,
	input wire logic        osc_switch_done_in,
	input wire logic        wdt_enabled_out,
	input wire logic        clk_source_on_out,
	input wire logic [1:0]  clk_source_used_out,
	input wire logic        timeout_flag_out,
	input wire logic        sleep_flag_out,
	input wire logic        wake_out,
	input wire logic        device_reset_out,
	input wire logic [15:0] post_count_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	sequence s_held_off;
		(watchdog_enable_cfg_in == EN_ALWAYS_OFF) [*3];
	endsequence
	sequence s_asleep;
		power_save_sleep_in ##1 !power_save_exit_in [*2];
	endsequence
	a_off_holds_zero: assert property (s_held_off |-> !wdt_enabled_out && post_count_out == 16'h0000)
		else $error("counter runs while off");
	a_source_follows: assert property (1'b1 |-> clk_source_on_out == wdt_enabled_out)
		else $error("clock source request wrong");
	a_reset_one_cycle: assert property (device_reset_out |=> !device_reset_out)
		else $error("reset pulse too long");
	a_wake_one_cycle: assert property (wake_out |=> !wake_out)
		else $error("wake pulse too long");
	a_flag_sticky: assert property (timeout_flag_out && !timeout_flag_clr_in |=> timeout_flag_out)
		else $error("flag dropped");
	a_flag_with_event: assert property (device_reset_out || wake_out |-> timeout_flag_out)
		else $error("flag missing");
	a_events_clear: assert property (power_save_sleep_in || power_save_exit_in || osc_switch_done_in
		|=> post_count_out == 16'h0000)
		else $error("count not cleared");
	a_sleep_flag_set: assert property (power_save_sleep_in |=> sleep_flag_out)
		else $error("sleep flag missing");
	a_sleep_on_rc: assert property (s_asleep |-> clk_source_used_out == CLK_SEL_RC)
		else $error("sleep not on RC");
endmodule
bind wdt_top wdt_chk u_wdt_chk (.mclk_in, .srst_in, .watchdog_enable_cfg_in, .timeout_flag_clr_in,
	.power_save_sleep_in, .power_save_exit_in, .osc_switch_done_in, .wdt_enabled_out,
	.clk_source_on_out, .clk_source_used_out, .timeout_flag_out, .sleep_flag_out, .wake_out,
	.device_reset_out, .post_count_out);
`default_nettype wire

// ---- tb/tb_wdt_top.sv ----
// Self-checking testbench for the windowed watchdog timer.
`timescale 1ns/1ns
`default_nettype none
module tb_wdt_top;
	import wdt_pkg::*;
	logic        mclk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        tick    = 1'b0;
	logic [1:0]  src     = 2'h0;
	logic        pre     = 1'b0;
	logic [3:0]  post    = 4'h0;
	logic        wdis    = 1'b1;
	logic [1:0]  encf    = 2'h3;
	logic [6:0]  pl      = 7'h00;
	logic [15:0] cnt;
	wire logic   en_o, src_o, sw_o, to_o, sl_o, id_o, wk_o, rs_o;
	int          n_mismatch = 0, total_checks = 0, n_rst = 0, n_wake = 0, cyc = 0, rb, rw;
	wdt_top u_wdt_top (.mclk_in, .srst_in, .rc_tick_in(tick), .sec_osc_tick_in(tick),
		.systmr_tick_in(tick), .clk_source_sel_in(src), .prescale_select_cfg_in(pre),
		.postscale_select_cfg_in(post), .window_disable_cfg_in(wdis),
		.watchdog_enable_cfg_in(encf), .soft_watchdog_enable_set_in(pl[5]),
		.soft_watchdog_enable_clr_in(1'b0), .timeout_flag_clr_in(pl[6]), .sleep_flag_clr_in(1'b0),
		.idle_flag_clr_in(1'b0), .watchdog_clear_instr_in(pl[0]), .power_save_sleep_in(pl[1]),
		.power_save_idle_in(pl[2]), .power_save_exit_in(pl[3]), .osc_switch_done_in(pl[4]),
		.wdt_enabled_out(en_o), .clk_source_on_out(src_o), .clk_source_used_out(),
		.soft_watchdog_enable_out(sw_o), .timeout_flag_out(to_o), .sleep_flag_out(sl_o),
		.idle_flag_out(id_o), .wake_out(wk_o), .device_reset_out(rs_o), .post_count_out(cnt));
	always #50 mclk_in = ~mclk_in;
	// One source tick every four cycles keeps the ticks well below half the core clock.
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		tick <= cyc[1];
		n_rst <= n_rst + int'(rs_o);
		n_wake <= n_wake + int'(wk_o);
		if (cyc == 40000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic close_out();
		if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge mclk_in);
		#10;
	endtask
	task automatic go(input int k);
		@(posedge mclk_in);
		pl <= 7'h01 << k;
		cy(1);
		pl <= 7'h00;
	endtask
	// Tick phase and the input synchroniser blur the edge by a few cycles.
	task automatic tmo(input int e);
		int n = 0;
		int r = n_rst + n_wake;
		while (n_rst + n_wake == r && n < e + 8) begin
			cy(1);
			n++;
		end
		chk(16'(n >= e - 8 && n < e + 8), 16'h1);
	endtask
	initial begin
		repeat (6) @(posedge mclk_in);
		srst_in <= 1'b0;
		cy(2);
		chk({sw_o, to_o, sl_o, id_o}, 16'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk_in);
			pre <= i[0];
			post <= 4'(i);
			src <= 2'(i);
			go(0);
			tmo((i[0] ? 512 : 128) << i);
			cy(20);
			chk(to_o, 1);
			go(6);
			cy(1);
			chk(to_o, 0);
		end
		@(posedge mclk_in);
		{pre, post, wdis} <= 6'h08;
		go(0);
		cy(200);
		chk(cnt, 16'h1);
		rb = n_rst;
		go(0);
		cy(2);
		chk(n_rst - rb, 1);
		go(6);
		cy(1600);
		chk(cnt, 16'hc);
		rb = n_rst;
		go(0);
		cy(2);
		chk(16'(n_rst - rb), 16'h0);
		chk(cnt, 16'h0);
		wdis <= 1'b1;
		encf <= 2'h2;
		go(0);
		cy(200);
		chk({15'h0, en_o}, 16'h0);
		chk(cnt, 16'h0);
		go(5);
		cy(200);
		chk({13'h0, en_o, sw_o, src_o}, 16'h7);
		chk(cnt, 16'h1);
		encf <= 2'h0;
		cy(4);
		chk(en_o, 0);
		srst_in <= 1'b1;
		cy(1);
		srst_in <= 1'b0;
		encf <= 2'h3;
		cy(1);
		chk(sw_o, 0);
		{rb, rw} = {n_rst, n_wake};
		go(1);
		tmo(2048);
		chk(16'(n_rst - rb), 16'h0);
		chk(16'(n_wake - rw), 16'h1);
		chk({15'h0, sl_o}, 16'h1);
		go(2);
		cy(200);
		chk({15'h0, id_o}, 16'h1);
		chk(cnt, 16'h1);
		go(4);
		chk(cnt, 16'h0);
		cy(200);
		go(3);
		chk(cnt, 16'h0);
		close_out();
	end
endmodule
`default_nettype wire
